// file: hdl/esv_pkg.sv
// Purpose: constants for the event and software interrupt vectoring block
// Assumes: one core clock, asynchronous active-high reset
// Notes: vectors are 16-bit byte addresses, event vectors in page zero, software vectors in page one
package esv_pkg;
    localparam int          ESV_NUM_EVT    = 9;
    localparam int          ESV_NUM_SW     = 7;
    localparam int          ESV_NUM_SRC    = ESV_NUM_EVT + ESV_NUM_SW;
    localparam int          ESV_PRIO_W     = 4;
    localparam int          ESV_FIELD_W    = 3;
    localparam int          ESV_VEC_W      = 16;
    localparam int          ESV_LO_POS     = 0;
    localparam int          ESV_HI_POS     = 4;
    localparam logic [3:0]  ESV_PRIO_BIAS  = 4'h8;
    localparam logic [15:0] ESV_SW_BASE    = 16'h0100;
    localparam logic [15:0] ESV_SW_STEP    = 16'h0004;
    localparam logic [7:0]  ESV_PRIO_RST   = 8'h00;
    localparam logic [15:0] ESV_VEC_RST    = 16'h0000;
    // event vectors in rank order 2..10
    localparam logic [15:0] ESV_EVT_VEC [ESV_NUM_EVT] = '{
        16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090,
        16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac};
endpackage : esv_pkg

// file: hdl/esv_src_if.sv
`timescale 1ns/1ps
// Purpose: per-source request, priority and vector bundle
// Assumes: index 0..8 events in rank order, 9..15 software 1..7
// Notes: none
interface esv_src_if;
    import esv_pkg::*;
    logic [ESV_NUM_SRC-1:0] req;
    logic [ESV_PRIO_W-1:0]  prio [ESV_NUM_SRC];
    logic [ESV_VEC_W-1:0]   vec  [ESV_NUM_SRC];
    logic                   any;
    logic [ESV_PRIO_W-1:0]  win_prio;
    logic [ESV_VEC_W-1:0]   win_vec;
    modport src (output req, prio, vec, input any, win_prio, win_vec);
    modport arb (input req, prio, vec, output any, win_prio, win_vec);
endinterface : esv_src_if

// file: hdl/esv_arbiter.sv
`timescale 1ns/1ps
// Purpose: pick highest priority request, lowest index on a tie
// Assumes: inputs already gated
// Notes: purely combinational
module esv_arbiter
    import esv_pkg::*;
(
    esv_src_if.arb s
);
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s.any      = 1'b0;
        s.win_prio = '0;
        s.win_vec  = ESV_VEC_RST;
        // strict greater keeps the lower index on ties
        for (int i = 0; i < ESV_NUM_SRC; i++) begin
            if (s.req[i] && (!s.any || s.prio[i] > s.win_prio)) begin
                s.any      = 1'b1;
                s.win_prio = s.prio[i];
                s.win_vec  = s.vec[i];
            end
        end
    end
endmodule : esv_arbiter

// file: hdl/esv_vectoring.sv
`timescale 1ns/1ps
// Purpose: event and software interrupt source table with vector selection
// Assumes: flags and config inputs synchronous to clk_i
// Notes: outputs registered, one cycle after inputs
module esv_vectoring
    import esv_pkg::*;
(
    input  wire logic                   clk_i,
    input  wire logic                   reset_i,
    input  wire logic                   ext_irq0_flag_i,
    input  wire logic                   timer0_overflow_flag_i,
    input  wire logic                   ext_irq1_flag_i,
    input  wire logic                   timer1_overflow_flag_i,
    input  wire logic                   timer2_overflow_flag_i,
    input  wire logic                   timer2_external_flag_i,
    input  wire logic                   uart0_rx_done_flag_i,
    input  wire logic                   uart0_tx_done_flag_i,
    input  wire logic                   uart1_rx_done_flag_i,
    input  wire logic                   uart1_tx_done_flag_i,
    input  wire logic                   global_irq_enable_i,
    input  wire logic                   ext_irq0_enable_i,
    input  wire logic                   timer0_irq_enable_i,
    input  wire logic                   ext_irq1_enable_i,
    input  wire logic                   timer1_irq_enable_i,
    input  wire logic                   timer2_irq_enable_i,
    input  wire logic                   uart0_rx_irq_enable_i,
    input  wire logic                   uart0_tx_irq_enable_i,
    input  wire logic                   uart1_rx_irq_enable_i,
    input  wire logic                   uart1_tx_irq_enable_i,
    input  wire logic [7:0]             prio_cfg_a_i,
    input  wire logic [7:0]             prio_cfg_b_i,
    input  wire logic [7:0]             prio_cfg_c_i,
    input  wire logic [7:0]             prio_cfg_e_i,
    input  wire logic [7:0]             prio_cfg_f_i,
    input  wire logic [ESV_NUM_SW-1:0]  soft_irq_request_i,
    input  wire logic [ESV_NUM_SW-1:0]  soft_irq_enable_i,
    output logic                        irq_valid_o,
    output logic [ESV_PRIO_W-1:0]       irq_prio_o,
    output logic [ESV_VEC_W-1:0]        irq_vector_o,
    output logic [ESV_NUM_SRC-1:0]      irq_pending_o
);
    ////////////////////////////////////////////////////////////////////////
    // event sources in rank order
    esv_src_if s ();

    wire logic [ESV_NUM_EVT-1:0] evt_flag = {
        uart1_tx_done_flag_i, uart1_rx_done_flag_i,
        uart0_tx_done_flag_i, uart0_rx_done_flag_i,
        timer2_overflow_flag_i | timer2_external_flag_i,
        timer1_overflow_flag_i, ext_irq1_flag_i,
        timer0_overflow_flag_i, ext_irq0_flag_i};
    wire logic [ESV_NUM_EVT-1:0] evt_en = {
        uart1_tx_irq_enable_i, uart1_rx_irq_enable_i,
        uart0_tx_irq_enable_i, uart0_rx_irq_enable_i,
        timer2_irq_enable_i, timer1_irq_enable_i, ext_irq1_enable_i,
        timer0_irq_enable_i, ext_irq0_enable_i};
    wire logic [ESV_FIELD_W-1:0] evt_field [ESV_NUM_EVT];
    assign evt_field[0] = prio_cfg_a_i[ESV_LO_POS +: ESV_FIELD_W];
    assign evt_field[1] = prio_cfg_a_i[ESV_HI_POS +: ESV_FIELD_W];
    assign evt_field[2] = prio_cfg_b_i[ESV_LO_POS +: ESV_FIELD_W];
    assign evt_field[3] = prio_cfg_b_i[ESV_HI_POS +: ESV_FIELD_W];
    assign evt_field[4] = prio_cfg_c_i[ESV_LO_POS +: ESV_FIELD_W];
    assign evt_field[5] = prio_cfg_e_i[ESV_LO_POS +: ESV_FIELD_W];
    assign evt_field[6] = prio_cfg_e_i[ESV_HI_POS +: ESV_FIELD_W];
    assign evt_field[7] = prio_cfg_f_i[ESV_LO_POS +: ESV_FIELD_W];
    assign evt_field[8] = prio_cfg_f_i[ESV_HI_POS +: ESV_FIELD_W];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < ESV_NUM_EVT; g++) begin : g_evt
            wire logic nz = (evt_field[g] != '0);
            assign s.prio[g] = nz ? ({1'b0, evt_field[g]} + ESV_PRIO_BIAS) : '0;
            assign s.req[g]  = evt_flag[g] & evt_en[g] & global_irq_enable_i & nz;
            assign s.vec[g]  = ESV_EVT_VEC[g];
        end
        for (g = 0; g < ESV_NUM_SW; g++) begin : g_sw
            assign s.prio[ESV_NUM_EVT+g] = ESV_PRIO_W'(g + 1);
            assign s.req[ESV_NUM_EVT+g]  = soft_irq_request_i[g] & soft_irq_enable_i[g];
            assign s.vec[ESV_NUM_EVT+g]  = ESV_SW_BASE + ESV_SW_STEP * ESV_VEC_W'(g);
        end
    endgenerate

    esv_arbiter u_arb (.s(s));

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            irq_valid_o   <= 1'b0;
            irq_prio_o    <= '0;
            irq_vector_o  <= ESV_VEC_RST;
            irq_pending_o <= '0;
        end else begin
            irq_valid_o   <= s.any;
            irq_prio_o    <= s.win_prio;
            irq_vector_o  <= s.win_vec;
            irq_pending_o <= s.req;
        end
    end
endmodule : esv_vectoring

// file: tb/esv_vectoring_asserts.sv
`timescale 1ns/1ps
// Purpose: port-level checks of the vectoring block
// Assumes: outputs lag inputs by one edge
// Notes: bound into esv_vectoring
module esv_vectoring_chk
    import esv_pkg::*;
(
    input wire logic        clk_i, reset_i, global_irq_enable_i, ext_irq0_flag_i, ext_irq0_enable_i,
    input wire logic        timer0_overflow_flag_i, timer0_irq_enable_i, irq_valid_o,
    input wire logic [7:0]  prio_cfg_a_i,
    input wire logic [6:0]  soft_irq_request_i, soft_irq_enable_i,
    input wire logic [3:0]  irq_prio_o,
    input wire logic [15:0] irq_vector_o, irq_pending_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    AST_EXT0_REQ: assert property (1 |=> irq_pending_o[0] == $past(ext_irq0_flag_i & ext_irq0_enable_i
        & global_irq_enable_i & |prio_cfg_a_i[2:0])) else $error("ext0 request mismatch");
    AST_TMR0_REQ: assert property (1 |=> irq_pending_o[1] == $past(timer0_overflow_flag_i
        & timer0_irq_enable_i & global_irq_enable_i & |prio_cfg_a_i[6:4])) else $error("timer0 request mismatch");
    AST_SW_REQ: assert property (1 |=> irq_pending_o[15:9] == $past(soft_irq_request_i & soft_irq_enable_i))
        else $error("soft request mismatch");
    AST_GLOBAL_OFF: assert property (!global_irq_enable_i |=> irq_pending_o[8:0] == 9'h000)
        else $error("event pending with global off");
    AST_VALID: assert property (irq_valid_o == |irq_pending_o) else $error("valid mismatch");
    AST_SW_VEC: assert property (irq_valid_o && !irq_prio_o[3] |->
        irq_vector_o == 16'h0100 + {irq_prio_o - 4'h1, 2'b00}) else $error("soft vector mismatch");
    AST_EVT_PRIO: assert property (|irq_pending_o[8:0] |-> irq_prio_o[3] && irq_prio_o != 4'h8)
        else $error("event priority out of range");
    AST_EXT0_TOP: assert property (ext_irq0_flag_i && ext_irq0_enable_i && global_irq_enable_i
        && prio_cfg_a_i[2:0] == 3'h7 |=> irq_prio_o == 4'hf && irq_vector_o == 16'h0080) else $error("ext0 lost");
endmodule : esv_vectoring_chk
bind esv_vectoring esv_vectoring_chk esv_vectoring_chk_inst (.*);

// file: tb/esv_core_model.sv
`timescale 1ns/1ps
// Purpose: core side that takes the offered vector
// Assumes: any valid offer is taken at once
// Notes: no level masking modelled
module esv_core_model (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        irq_valid_i,
    input  wire logic [15:0] irq_vector_i,
    output logic      [15:0] taken_vector_o
);
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) taken_vector_o <= 16'h0000;
        else if (irq_valid_i) taken_vector_o <= irq_vector_i;
    end
endmodule : esv_core_model

// file: tb/testbench.sv
`timescale 1ns/1ps
// Purpose: directed checks of the vectoring block
// Assumes: outputs settle one edge after inputs
// Notes: one spare edge lets the core model take the vector
module testbench;
    import esv_pkg::*;
    logic        clk_i = 1'b0, reset_i = 1'b1, g = 1'b0, vld;
    logic [9:0]  flg = '0;
    logic [8:0]  en = '0;
    logic [7:0]  pc [5] = '{default: 8'h11};
    logic [6:0]  swr = '0, swe = '0;
    logic [3:0]  pri;
    logic [15:0] vec, pnd, taken;
    int          error_cnt = 0, compares = 0;
    always #5 clk_i = ~clk_i;
    esv_vectoring esv_vectoring_inst (.clk_i(clk_i), .reset_i(reset_i), .global_irq_enable_i(g),
        .ext_irq0_flag_i(flg[0]), .timer0_overflow_flag_i(flg[1]), .ext_irq1_flag_i(flg[2]),
        .timer1_overflow_flag_i(flg[3]), .timer2_overflow_flag_i(flg[4]), .timer2_external_flag_i(flg[5]),
        .uart0_rx_done_flag_i(flg[6]), .uart0_tx_done_flag_i(flg[7]), .uart1_rx_done_flag_i(flg[8]),
        .uart1_tx_done_flag_i(flg[9]), .ext_irq0_enable_i(en[0]), .timer0_irq_enable_i(en[1]),
        .ext_irq1_enable_i(en[2]), .timer1_irq_enable_i(en[3]), .timer2_irq_enable_i(en[4]),
        .uart0_rx_irq_enable_i(en[5]), .uart0_tx_irq_enable_i(en[6]), .uart1_rx_irq_enable_i(en[7]),
        .uart1_tx_irq_enable_i(en[8]), .prio_cfg_a_i(pc[0]), .prio_cfg_b_i(pc[1]), .prio_cfg_c_i(pc[2]),
        .prio_cfg_e_i(pc[3]), .prio_cfg_f_i(pc[4]), .soft_irq_request_i(swr), .soft_irq_enable_i(swe),
        .irq_valid_o(vld), .irq_prio_o(pri), .irq_vector_o(vec), .irq_pending_o(pnd));
    esv_core_model esv_core_model_inst (.clk_i(clk_i), .reset_i(reset_i), .irq_valid_i(vld),
        .irq_vector_i(vec), .taken_vector_o(taken));
    task automatic cmp(input logic [36:0] seen, input logic [36:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : cmp
    task automatic drv(input logic [9:0] f, input logic [8:0] e, input logic gl, input logic [6:0] r, s);
        @(posedge clk_i);
        {flg, en, g, swr, swe} <= {f, e, gl, r, s};
    endtask : drv
    task automatic chk(input logic [3:0] p, input logic [15:0] v, input logic [15:0] m);
        repeat (2) @(posedge clk_i);
        #1;
        cmp({vld, pri, vec, pnd}, {|m, p, v, m});
        if (|m) cmp({21'h0, taken}, {21'h0, v});
    endtask : chk
    task automatic test_done();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : test_done
    initial begin
        #5000;
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        test_done();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < ESV_NUM_EVT; i++) begin
            drv(10'h3ff << (i + int'(i > 4)), 9'h1ff, 1'b1, 7'h7f, 7'h7f);
            chk(4'h9, ESV_EVT_VEC[i], {7'h7f, 9'h1ff << i});
        end
        drv(10'h020, 9'h010, 1'b1, 7'h00, 7'h00);
        chk(4'h9, 16'h0090, 16'h0010);
        drv(10'h0c0, 9'h060, 1'b1, 7'h00, 7'h00);
        pc[3] <= 8'h21;
        chk(4'ha, 16'h00a4, 16'h0060);
        drv(10'h300, 9'h180, 1'b1, 7'h00, 7'h00);
        pc[4] <= 8'h12;
        chk(4'ha, 16'h00a8, 16'h0180);
        $display("rank test end");
        drv(10'h003, 9'h003, 1'b1, 7'h00, 7'h00);
        pc[0] <= 8'h71;
        chk(4'hf, 16'h0084, 16'h0003);
        drv(10'h003, 9'h003, 1'b1, 7'h00, 7'h00);
        pc[0] <= 8'h77;
        chk(4'hf, 16'h0080, 16'h0003);
        drv(10'h001, 9'h1ff, 1'b1, 7'h00, 7'h7f);
        pc[0] <= 8'h70;
        chk(4'h0, 16'h0000, 16'h0000);
        drv(10'h3ff, 9'h000, 1'b1, 7'h7f, 7'h00);
        chk(4'h0, 16'h0000, 16'h0000);
        drv(10'h3ff, 9'h1ff, 1'b0, 7'h7f, 7'h7f);
        chk(4'h7, 16'h0118, 16'hfe00);
        $display("masking test end");
        for (int n = 1; n <= ESV_NUM_SW; n++) begin
            drv(10'h000, 9'h1ff, 1'b1, 7'h01 << (n - 1), 7'h7f);
            chk(4'(n), 16'h0100 + 16'(4 * (n - 1)), {7'h01 << (n - 1), 9'h000});
        end
        $display("software test end");
        test_done();
    end
endmodule : testbench
